/* hw/cdcc_defines.svh */
// Constants for the processor datapath and instruction cycle control
// Function
// - Four 36-bit registers: buffer, accumulator, in-out, carry
// - All memory words pass the memory buffer
// - Fetch loads left six buffer bits into instruction
// - Buffer address feeds adder, address, counter, control
// - Address registers 15 bits, widenable to 18
// - Address register loads from counter, adder, buffer
// - Program counter holds next instruction address
// - Index adder sums base and index register
// - Jump-and-save keeps old counter in adder
// - Adder counts shift, multiply, divide steps
// - Accumulator takes sums, high product, remainder
// - AND, OR, XOR results go to accumulator
// - In-out holds low product and quotient
// - In-out shifts and carries external data
// - Six flags set, cleared, tested; all-zero too
// - Six sense switches tested singly or all-zero
// - Test address and word switches feed console
// - Memory instructions two cycles, jumps and others one
// - Shift takes one cycle plus per-step time
// - Multiply and divide time follow ones count
// - Indexing and each indirect level add cycle
// - In-out completion starts next instruction
// - Index addition is ones-complement, end-around carry
// - Zero index field means no indexing cycle
`ifndef CDCC_DEFINES_SVH
`define CDCC_DEFINES_SVH

`define CDCC_DW         36
`define CDCC_AW         15
`define CDCC_CLK_NS     10
`define CDCC_CYC_NS     5000
`define CDCC_STEP_NS    200
`define CDCC_CYC_TICKS  (`CDCC_CYC_NS / `CDCC_CLK_NS)
`define CDCC_STEP_TICKS (`CDCC_STEP_NS / `CDCC_CLK_NS)
`define CDCC_MD_STEPS   15'h0024

`define CDCC_OP_AND 6'h02
`define CDCC_OP_IOR 6'h04
`define CDCC_OP_XOR 6'h06
`define CDCC_OP_LAC 6'h10
`define CDCC_OP_LIO 6'h12
`define CDCC_OP_DAC 6'h14
`define CDCC_OP_DIO 6'h16
`define CDCC_OP_ADD 6'h20
`define CDCC_OP_SUB 6'h22
`define CDCC_OP_MUL 6'h2C
`define CDCC_OP_DIV 6'h2E
`define CDCC_OP_JMP 6'h30
`define CDCC_OP_JSP 6'h32
`define CDCC_OP_SKP 6'h34
`define CDCC_OP_SFT 6'h36
`define CDCC_OP_IOT 6'h3A
`define CDCC_OP_OPR 6'h3E

`define CDCC_REG_CTRL 8'h00
`define CDCC_REG_STAT 8'h04
`define CDCC_REG_ACL  8'h08
`define CDCC_REG_ACH  8'h0C
`define CDCC_REG_IOL  8'h10
`define CDCC_REG_IOH  8'h14
`define CDCC_REG_MBL  8'h18
`define CDCC_REG_MBH  8'h1C
`define CDCC_REG_CSL  8'h20
`define CDCC_REG_CSH  8'h24
`define CDCC_REG_PC   8'h28
`define CDCC_REG_MA   8'h2C
`define CDCC_REG_IA   8'h30
`define CDCC_REG_MISC 8'h34

`define CDCC_CTRL_START 0
`define CDCC_CTRL_EXAM  1
`define CDCC_CTRL_DEP   2
`define CDCC_CTRL_STOP  3

`endif

/* hw/cdcc_pkg.sv */
// Types shared by the processor datapath and cycle control
package cdcc_pkg;
	typedef enum logic [2:0] {
		S_IDLE  = 3'b000,
		S_FETCH = 3'b001,
		S_INDEX = 3'b010,
		S_DEFER = 3'b011,
		S_EXEC  = 3'b100,
		S_STEP  = 3'b101,
		S_IOW   = 3'b110,
		S_MAN   = 3'b111
	} cdcc_state_t;

	typedef struct packed {
		logic [17:0] addr;
		logic [35:0] wdata;
		logic        rd;
		logic        wr;
	} cdcc_mem_req_t;

	typedef struct packed {
		logic [35:0] data;
		logic [17:0] cmd;
		logic        strobe;
	} cdcc_io_req_t;
endpackage : cdcc_pkg

/* hw/cdcc_core.sv */
// Processor register datapath and memory cycle sequencer
`timescale 1ns/1ps
`include "cdcc_defines.svh"
module cdcc_core
	import cdcc_pkg::*;
#(
	parameter int AW         = `CDCC_AW,
	parameter int CYC_TICKS  = `CDCC_CYC_TICKS,
	parameter int STEP_TICKS = `CDCC_STEP_TICKS
) (
	// Clock and reset
	input  wire logic          pclk,
	input  wire logic          presetn,
	// APB slave
	input  wire logic [7:0]    paddr,
	input  wire logic          psel,
	input  wire logic          penable,
	input  wire logic          pwrite,
	input  wire logic [31:0]   pwdata,
	output logic      [31:0]   prdata,
	output logic               pready,
	output logic               pslverr,
	// Core memory
	output cdcc_mem_req_t      mem_req,
	input  wire logic [35:0]   mem_rdata,
	// Console switches
	input  wire logic [AW-1:0] test_addr,
	input  wire logic [35:0]   test_word,
	input  wire logic [5:0]    sense_sw,
	// In-out equipment
	output cdcc_io_req_t       io_req,
	input  wire logic          io_done,
	input  wire logic [35:0]   io_rdata
);

	cdcc_state_t     state;
	cdcc_state_t     next_state;
	logic [15:0]     cnt;
	logic [15:0]     stp;
	logic [15:0]     slen;
	logic [35:0]     mb;
	logic [35:0]     acc;
	logic [35:0]     io;
	logic [35:0]     cs;
	logic [AW-1:0]   ma;
	logic [AW-1:0]   pc;
	logic [AW-1:0]   ia;
	logic [AW-1:0]   next_ma;
	logic [AW-1:0]   io_cmd;
	logic [5:0]      ir;
	logic [5:0]      flags;
	logic [5:0]      cop;
	logic            mrd;
	logic            mwr;
	logic            next_rd;
	logic            next_wr;
	logic            dfr;
	logic            stop_pend;
	logic            io_stb;
	logic            cmd_start;
	logic            cmd_exam;
	logic            cmd_dep;
	logic            cmd_stop;
	logic            mem_st;
	logic            cyc_end;
	logic            samp;
	logic            memop;
	logic            need_x;
	logic            need_d;
	logic            skip_hit;
	logic            step_fire;
	logic            q_one;
	logic [AW-1:0]   ea;
	logic [AW-1:0]   ia_sum;
	logic [AW-1:0]   pc_inc;
	logic [AW-1:0]   pc_nx;
	logic [36:0]     msum;
	logic [36:0]     drem;
	cdcc_state_t     fn_state;
	logic            fn_rd;

	function automatic logic [AW-1:0] oc_adda(input logic [AW-1:0] a, input logic [AW-1:0] b);
		logic [AW:0] s;
		s = {1'b0, a} + {1'b0, b};
		oc_adda = s[AW-1:0] + AW'(s[AW]);
	endfunction : oc_adda

	function automatic logic [35:0] oc_add36(input logic [35:0] a, input logic [35:0] b);
		logic [36:0] s;
		s = {1'b0, a} + {1'b0, b};
		oc_add36 = s[35:0] + {35'h0, s[36]};
	endfunction : oc_add36

	function automatic logic is_mem(input logic [5:0] op);
		case (op)
			`CDCC_OP_AND, `CDCC_OP_IOR, `CDCC_OP_XOR, `CDCC_OP_LAC, `CDCC_OP_LIO,
			`CDCC_OP_DAC, `CDCC_OP_DIO, `CDCC_OP_ADD, `CDCC_OP_SUB, `CDCC_OP_MUL,
			`CDCC_OP_DIV, `CDCC_OP_JMP, `CDCC_OP_JSP: is_mem = 1'b1;
			default: is_mem = 1'b0;
		endcase
	endfunction : is_mem

	// Drives straight from the buffer, address and strobe registers
	assign mem_req = '{addr: 18'(ma), wdata: mb, rd: mrd, wr: mwr};
	assign io_req  = '{data: io, cmd: 18'(io_cmd), strobe: io_stb};

	assign mem_st  = state inside {S_FETCH, S_INDEX, S_DEFER, S_EXEC, S_MAN};
	assign cyc_end = mem_st && (cnt == 16'(CYC_TICKS - 1));
	assign samp    = mem_st && (cnt == 16'(CYC_TICKS - 2));
	assign cop     = (state == S_FETCH) ? mb[35:30] : ir;
	assign memop   = is_mem(cop);
	assign ia_sum  = oc_adda(ia, mb[AW-1:0]);
	assign ea      = (state == S_INDEX) ? ia_sum : mb[AW-1:0];
	assign need_x  = (state != S_INDEX) && (mb[26:18] != 9'h000);
	assign need_d  = (state == S_INDEX) ? dfr : mb[29];
	assign pc_inc  = (state == S_FETCH) ? pc + AW'(1) : pc;
	assign pc_nx   = pc_inc + AW'(skip_hit);
	assign msum    = {1'b0, acc} + (io[0] ? {1'b0, mb} : 37'h0);
	assign drem    = {acc, io[35]};
	assign q_one   = drem >= {1'b0, mb};
	assign fn_state = stop_pend ? S_IDLE : S_FETCH;
	assign fn_rd   = !stop_pend;
	assign step_fire = (state == S_STEP) && (ia != '0) && (stp == slen - 16'h0001);

	// Skip tests: flag select 1..6 or 7 for all zero, same for switches
	always_comb begin
		logic [2:0] fs;
		logic [2:0] ss;
		logic       ft;
		logic       st;
		fs = mb[2:0];
		ss = mb[5:3];
		ft = (fs == 3'h7) ? (flags == 6'h00) : ((fs != 3'h0) && flags[3'(fs - 3'h1)]);
		st = (ss == 3'h7) ? (sense_sw == 6'h00) : ((ss != 3'h0) && sense_sw[3'(ss - 3'h1)]);
		skip_hit = (state == S_FETCH) && (cop == `CDCC_OP_SKP) && (ft || st);
	end

	// Per-step time: short steps where the multiplier or quotient bit is zero
	always_comb begin
		case (ir)
			`CDCC_OP_MUL: slen = io[0] ? 16'(STEP_TICKS) : 16'h0001;
			`CDCC_OP_DIV: slen = q_one ? 16'(STEP_TICKS) : 16'h0001;
			default:      slen = 16'(STEP_TICKS);
		endcase
	end

	// Cycle-type sequencer
	always_comb begin
		next_state = state;
		next_ma    = ma;
		next_rd    = mrd;
		next_wr    = mwr;
		case (state)
			S_IDLE: begin
				if (cmd_start) begin
					next_state = S_FETCH;
					next_ma    = test_addr;
					next_rd    = 1'b1;
				end else if (cmd_exam || cmd_dep) begin
					next_state = S_MAN;
					next_ma    = test_addr;
					next_rd    = cmd_exam;
					next_wr    = cmd_dep;
				end
			end
			S_MAN: begin
				if (cyc_end) begin
					next_state = S_IDLE;
					next_rd    = 1'b0;
					next_wr    = 1'b0;
				end
			end
			S_FETCH, S_INDEX, S_DEFER: begin
				if (cyc_end) begin
					next_rd = 1'b0;
					next_wr = 1'b0;
					if (state == S_FETCH && !memop) begin
						if (cop == `CDCC_OP_SFT && mb[8:0] != 9'h000) begin
							next_state = S_STEP;
						end else if (cop == `CDCC_OP_IOT && mb[29]) begin
							next_state = S_IOW;
						end else if (cop == `CDCC_OP_OPR && mb[5]) begin
							next_state = S_IDLE;
						end else begin
							next_state = fn_state;
							next_ma    = pc_nx;
							next_rd    = fn_rd;
						end
					end else if (need_x) begin
						next_state = S_INDEX;
						next_ma    = AW'(mb[26:18]);
						next_rd    = 1'b1;
					end else if (need_d) begin
						next_state = S_DEFER;
						next_ma    = ea;
						next_rd    = 1'b1;
					end else if (cop == `CDCC_OP_JMP || cop == `CDCC_OP_JSP) begin
						next_state = fn_state;
						next_ma    = ea;
						next_rd    = fn_rd;
					end else begin
						next_state = S_EXEC;
						next_ma    = ea;
						next_wr    = (cop == `CDCC_OP_DAC) || (cop == `CDCC_OP_DIO);
						next_rd    = !((cop == `CDCC_OP_DAC) || (cop == `CDCC_OP_DIO));
					end
				end
			end
			S_EXEC: begin
				if (cyc_end) begin
					next_rd = 1'b0;
					next_wr = 1'b0;
					if (ir == `CDCC_OP_MUL || ir == `CDCC_OP_DIV) begin
						next_state = S_STEP;
					end else begin
						next_state = fn_state;
						next_ma    = pc;
						next_rd    = fn_rd;
					end
				end
			end
			S_STEP: begin
				// Last step hands over at once, so N steps cost exactly N step times
				if (ia == '0 || (step_fire && ia == AW'(1))) begin
					next_state = fn_state;
					next_ma    = pc;
					next_rd    = fn_rd;
				end
			end
			S_IOW: begin
				if (io_done) begin
					next_state = fn_state;
					next_ma    = pc;
					next_rd    = fn_rd;
				end
			end
			default: next_state = S_IDLE;
		endcase
	end

	// Memory cycle tick counter
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt <= 16'h0000;
		end else if (!mem_st || cyc_end) begin
			cnt <= 16'h0000;
		end else begin
			cnt <= cnt + 16'h0001;
		end
	end

	// Datapath registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state     <= S_IDLE;
			ma        <= '0;
			pc        <= '0;
			ia        <= '0;
			mb        <= 36'h0;
			acc       <= 36'h0;
			io        <= 36'h0;
			cs        <= 36'h0;
			ir        <= 6'h00;
			mrd       <= 1'b0;
			mwr       <= 1'b0;
			dfr       <= 1'b0;
			stp       <= 16'h0000;
			io_cmd    <= '0;
			io_stb    <= 1'b0;
			stop_pend <= 1'b0;
		end else begin
			state  <= next_state;
			ma     <= next_ma;
			mrd    <= next_rd;
			mwr    <= next_wr;
			io_stb <= 1'b0;
			stop_pend <= cmd_stop || (stop_pend && state != S_IDLE && next_state != S_IDLE);
			if (state == S_IDLE && cmd_start)
				pc <= test_addr;
			if (state == S_IDLE && cmd_dep)
				mb <= test_word;
			if (samp && !mwr)
				mb <= mem_rdata;
			if (next_state == S_EXEC && state != S_EXEC && next_wr)
				mb <= (cop == `CDCC_OP_DIO) ? io : acc;
			if (cyc_end) begin
				case (state)
					S_FETCH: begin
						ir  <= mb[35:30];
						pc  <= pc_nx;
						dfr <= mb[29];
						if (cop == `CDCC_OP_SFT) begin
							ia  <= AW'(mb[8:0]);
							stp <= 16'h0000;
						end
						if (cop == `CDCC_OP_IOT) begin
							io_cmd <= mb[AW-1:0];
							io_stb <= 1'b1;
						end
						if (cop == `CDCC_OP_OPR && mb[4])
							acc <= acc | test_word;
					end
					S_DEFER: dfr <= mb[29];
					S_INDEX: ia <= ia_sum;
					S_EXEC: begin
						stp <= 16'h0000;
						case (ir)
							`CDCC_OP_AND: acc <= acc & mb;
							`CDCC_OP_IOR: acc <= acc | mb;
							`CDCC_OP_XOR: acc <= acc ^ mb;
							`CDCC_OP_LAC: acc <= mb;
							`CDCC_OP_LIO: io <= mb;
							`CDCC_OP_ADD: acc <= oc_add36(acc, mb);
							`CDCC_OP_SUB: acc <= oc_add36(acc, ~mb);
							`CDCC_OP_MUL: begin
								// Multiplier moves to in-out, product builds in both
								ia  <= AW'(`CDCC_MD_STEPS);
								io  <= acc;
								acc <= 36'h0;
							end
							`CDCC_OP_DIV: ia <= (acc >= mb) ? '0 : AW'(`CDCC_MD_STEPS);
							default: ;
						endcase
					end
					default: ;
				endcase
				if ((state == S_FETCH || state == S_DEFER) && memop && need_x)
					ia <= mb[AW-1:0];
				if (state != S_EXEC && state != S_MAN && memop && !need_x && !need_d
					&& (cop == `CDCC_OP_JMP || cop == `CDCC_OP_JSP)) begin
					pc <= ea;
					if (cop == `CDCC_OP_JSP)
						ia <= pc_inc;
				end
			end
			if (state == S_STEP && ia != '0) begin
				if (step_fire) begin
					stp <= 16'h0000;
					ia  <= ia - AW'(1);
					case (ir)
						`CDCC_OP_MUL: begin
							acc <= msum[36:1];
							io  <= {msum[0], io[35:1]};
							cs  <= {35'h0, msum[36]};
						end
						`CDCC_OP_DIV: begin
							acc <= q_one ? 36'(drem - {1'b0, mb}) : drem[35:0];
							io  <= {io[34:0], q_one};
						end
						default: begin
							case ({mb[10], mb[9]})
								2'b11:   io <= {io[35], io[33:0], io[35]};
								2'b10:   io <= {io[34:0], 1'b0};
								2'b01:   io <= {io[35], io[35:1]};
								default: io <= {1'b0, io[35:1]};
							endcase
						end
					endcase
				end else begin
					stp <= stp + 16'h0001;
				end
			end
			if (state == S_IOW && io_done)
				io <= io_rdata;
		end
	end

	// Program flags, one flip-flop each
	genvar gi;
	for (gi = 0; gi < 6; gi++) begin : g_flag
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				flags[gi] <= 1'b0;
			end else if (state == S_FETCH && cyc_end && cop == `CDCC_OP_OPR
				&& (mb[2:0] == 3'(gi + 1) || mb[2:0] == 3'h7)) begin
				flags[gi] <= mb[3];
			end
		end
	end

	// APB slave, zero wait states, read data latched in the setup cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata    <= 32'h0;
			pready    <= 1'b0;
			pslverr   <= 1'b0;
			cmd_start <= 1'b0;
			cmd_exam  <= 1'b0;
			cmd_dep   <= 1'b0;
			cmd_stop  <= 1'b0;
		end else begin
			pready    <= psel && !penable;
			cmd_start <= 1'b0;
			cmd_exam  <= 1'b0;
			cmd_dep   <= 1'b0;
			cmd_stop  <= 1'b0;
			if (psel && !penable) begin
				pslverr <= 1'b0;
				prdata  <= 32'h0;
				if (paddr == `CDCC_REG_CTRL)
					prdata <= 32'h0;
				else if (paddr == `CDCC_REG_STAT)
					prdata <= {27'h0, state, stop_pend, state != S_IDLE};
				else if (paddr == `CDCC_REG_ACL)
					prdata <= acc[31:0];
				else if (paddr == `CDCC_REG_ACH)
					prdata <= {28'h0, acc[35:32]};
				else if (paddr == `CDCC_REG_IOL)
					prdata <= io[31:0];
				else if (paddr == `CDCC_REG_IOH)
					prdata <= {28'h0, io[35:32]};
				else if (paddr == `CDCC_REG_MBL)
					prdata <= mb[31:0];
				else if (paddr == `CDCC_REG_MBH)
					prdata <= {28'h0, mb[35:32]};
				else if (paddr == `CDCC_REG_CSL)
					prdata <= cs[31:0];
				else if (paddr == `CDCC_REG_CSH)
					prdata <= {28'h0, cs[35:32]};
				else if (paddr == `CDCC_REG_PC)
					prdata <= 32'(pc);
				else if (paddr == `CDCC_REG_MA)
					prdata <= 32'(ma);
				else if (paddr == `CDCC_REG_IA)
					prdata <= 32'(ia);
				else if (paddr == `CDCC_REG_MISC)
					prdata <= {18'h0, flags, 2'b00, ir};
				else
					pslverr <= 1'b1;
			end
			if (psel && penable && pready && pwrite && paddr == `CDCC_REG_CTRL) begin
				cmd_start <= pwdata[`CDCC_CTRL_START];
				cmd_exam  <= pwdata[`CDCC_CTRL_EXAM];
				cmd_dep   <= pwdata[`CDCC_CTRL_DEP];
				cmd_stop  <= pwdata[`CDCC_CTRL_STOP];
			end
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_fetch_end;
		state == S_FETCH && cyc_end;
	endsequence

	sequence s_plain_mem;
		memop && mb[26:18] == 9'h000 && !mb[29]
			&& cop != `CDCC_OP_JMP && cop != `CDCC_OP_JSP;
	endsequence

	a_ir_load: assert property (s_fetch_end |=> ir == $past(mb[35:30]))
		else $error("instruction register not loaded from buffer");
	a_pc_advance: assert property (s_fetch_end ##0 (!memop && cop != `CDCC_OP_SKP)
		|=> pc == $past(pc) + AW'(1))
		else $error("program counter did not advance");
	a_fetch_addr: assert property ((state == S_FETCH && cnt == 16'h0000) |-> ma == pc)
		else $error("fetch address differs from program counter");
	a_no_index: assert property (s_fetch_end ##0 (memop && mb[26:18] == 9'h000)
		|=> state != S_INDEX)
		else $error("index cycle without index field");
	a_index_sum: assert property ((state == S_INDEX && cyc_end)
		|=> ia == oc_adda($past(ia), $past(mb[AW-1:0])))
		else $error("index sum wrong");
	a_two_cycle: assert property (s_fetch_end ##0 s_plain_mem |=> state == S_EXEC)
		else $error("memory instruction skipped its execute cycle");
	a_cycle_len: assert property (cnt <= 16'(CYC_TICKS - 1))
		else $error("memory cycle overran");
	a_io_wait: assert property ((state == S_IOW && !io_done) |=> state == S_IOW)
		else $error("in-out wait left before completion");
	a_step_count: assert property (step_fire |=> ia == $past(ia) - AW'(1))
		else $error("step counter did not decrement");

endmodule : cdcc_core

/* tb/cdcc_mem_model.sv */
// Core memory and in-out device model facing the processor
`timescale 1ns/1ps
module cdcc_mem_model
	import cdcc_pkg::*;
(
	// Clock
	input  wire logic          pclk,
	// Core memory
	input  wire cdcc_mem_req_t mem_req,
	output logic      [35:0]   mem_rdata,
	// In-out equipment
	input  wire cdcc_io_req_t  io_req,
	output logic               io_done,
	output logic      [35:0]   io_rdata
);
	logic [35:0] mem [0:32767];
	int          io_dly;
	logic [35:0] io_val;
	int          cnt;

	initial begin
		for (int i = 0; i < 32768; i++) begin
			mem[i] = 36'h0;
		end
		io_dly = 4;
		io_val = 36'h0;
		cnt = 0;
		io_done = 1'b0;
		io_rdata = 36'h0;
	end

	// Word shows only while a read cycle is open, its inverse otherwise
	assign mem_rdata = mem_req.rd ? mem[mem_req.addr[14:0]] : ~mem[mem_req.addr[14:0]];

	always @(posedge pclk) begin
		if (mem_req.wr) begin
			mem[mem_req.addr[14:0]] <= mem_req.wdata;
		end
	end

	// Device answers some clocks after the strobe, whether or not anyone waits
	always @(posedge pclk) begin
		io_done <= 1'b0;
		io_rdata <= ~io_rdata;
		if (io_req.strobe === 1'b1) begin
			cnt <= io_dly;
		end else if (cnt == 1) begin
			io_done <= 1'b1;
			io_rdata <= io_val;
			cnt <= 0;
		end else if (cnt > 1) begin
			cnt <= cnt - 1;
		end
	end
endmodule : cdcc_mem_model

/* tb/cdcc_core_bench.sv */
// Self-checking bench for the processor datapath and cycle control
`timescale 1ns/1ps
`include "cdcc_defines.svh"
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin err_count++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
module cdcc_core_bench
	import cdcc_pkg::*;
;
	localparam int          CT  = 8;
	localparam int          ST  = 2;
	localparam logic [35:0] OPA = 36'h70F0F0F0F;
	localparam logic [35:0] OPB = 36'h0FF00FF00;
	localparam logic [35:0] SV  = 36'h987654321;

	logic          pclk;
	logic          presetn;
	logic [7:0]    paddr;
	logic          psel;
	logic          penable;
	logic          pwrite;
	logic [31:0]   pwdata;
	logic [31:0]   prdata;
	logic          pready;
	logic          pslverr;
	cdcc_mem_req_t mem_req;
	logic [35:0]   mem_rdata;
	logic [14:0]   test_addr;
	logic [35:0]   test_word;
	logic [5:0]    sense_sw;
	cdcc_io_req_t  io_req;
	logic          io_done;
	logic [35:0]   io_rdata;
	int            err_count;
	int            checks;
	logic [31:0]   rq;
	logic          serr;
	logic [35:0]   v;
	logic [35:0]   e;
	logic [35:0]   hlt;
	logic [71:0]   p;
	logic [5:0]    op;
	logic [14:0]   y;

	cdcc_core #(.AW(15), .CYC_TICKS(CT), .STEP_TICKS(ST)) i_dut (
		.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .mem_req(mem_req), .mem_rdata(mem_rdata),
		.test_addr(test_addr), .test_word(test_word), .sense_sw(sense_sw),
		.io_req(io_req), .io_done(io_done), .io_rdata(io_rdata)
	);

	cdcc_mem_model i_mem (
		.pclk(pclk), .mem_req(mem_req), .mem_rdata(mem_rdata),
		.io_req(io_req), .io_done(io_done), .io_rdata(io_rdata)
	);

	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	function automatic logic [35:0] w(logic [5:0] o, logic i, logic [8:0] x, logic [14:0] a);
		return {o, i, 2'b00, x, 3'b000, a};
	endfunction : w

	task automatic ld(input logic [14:0] a, input logic [35:0] d);
		i_mem.mem[a] = d;
	endtask : ld

	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) err_count++;
		rq = prdata;
		serr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb

	task automatic rd36(input logic [7:0] a, output logic [35:0] r);
		apb(1'b0, a, 32'h0);
		r[31:0] = rq;
		apb(1'b0, a + 8'h04, 32'h0);
		r[35:32] = rq[3:0];
	endtask : rd36

	task automatic start(input logic [14:0] a, input logic [31:0] cmd);
		test_addr <= a;
		apb(1'b1, `CDCC_REG_CTRL, cmd);
	endtask : start

	// Busy span in clocks from the first memory cycle to the last
	task automatic tail(input int exp);
		int n;
		int last;
		n = 0;
		while (!(mem_req.rd | mem_req.wr) && n < 100) begin
			@(posedge pclk);
			n++;
		end
		n = 0;
		last = 0;
		while (n - last < 200) begin
			if (mem_req.rd | mem_req.wr) last = n + 1;
			@(posedge pclk);
			n++;
		end
		if (exp > 0) `CHK(last, exp)
	endtask : tail

	task automatic run(input logic [14:0] a, input int exp);
		start(a, 32'h1);
		tail(exp);
	endtask : run

	task automatic test_done;
		$display("checks=%0d err_count=%0d", checks, err_count);
		if (err_count == 0 && checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : test_done

	initial begin
		#500000;
		err_count++;
		test_done();
	end

	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		test_addr = 15'h0;
		test_word = 36'h0;
		sense_sw = 6'h00;
		err_count = 0;
		checks = 0;
		hlt = w(`CDCC_OP_OPR, 1'b0, 9'h0, 15'h0020);
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b1, `CDCC_REG_PC, 32'h0000_1234);
		apb(1'b0, `CDCC_REG_PC, 32'h0);
		`CHK(rq, 32'h0)
		apb(1'b0, 8'h38, 32'h0);
		`CHK({serr, rq}, 33'h1_0000_0000)
		ld(15'h0001, 36'h3);
		ld(15'h0002, 36'h013579BDF);
		ld(15'h0200, OPA);
		ld(15'h0201, OPB);
		for (int k = 0; k < 5; k++) begin
			case (k)
				0: begin op = `CDCC_OP_AND; e = OPA & OPB; end
				1: begin op = `CDCC_OP_IOR; e = OPA | OPB; end
				2: begin op = `CDCC_OP_XOR; e = OPA ^ OPB; end
				3: begin op = `CDCC_OP_ADD; e = OPA + OPB; end
				default: begin op = `CDCC_OP_SUB; e = OPA - OPB; end
			endcase
			ld(15'h0040, w(`CDCC_OP_LAC, 1'b0, 9'h0, 15'h0200));
			ld(15'h0041, w(op, 1'b0, 9'h0, 15'h0201));
			ld(15'h0042, w(`CDCC_OP_DAC, 1'b0, 9'h0, 15'h0300));
			ld(15'h0043, hlt);
			run(15'h0040, 7 * CT);
			rd36(`CDCC_REG_ACL, v);
			`CHK(v, e)
			`CHK(i_mem.mem[15'h0300], e)
		end
		// End-around carry: 7FFE plus 3 lands on 2
		ld(15'h0050, w(`CDCC_OP_LAC, 1'b0, 9'h001, 15'h7FFE));
		ld(15'h0051, hlt);
		run(15'h0050, 4 * CT);
		rd36(`CDCC_REG_ACL, v);
		`CHK(v, 36'h013579BDF)
		ld(15'h0058, w(`CDCC_OP_LAC, 1'b1, 9'h0, 15'h0060));
		ld(15'h0059, hlt);
		ld(15'h0060, w(6'h00, 1'b1, 9'h0, 15'h0061));
		ld(15'h0061, w(6'h00, 1'b0, 9'h0, 15'h0201));
		run(15'h0058, 5 * CT);
		rd36(`CDCC_REG_ACL, v);
		`CHK(v, OPB)
		ld(15'h005A, w(`CDCC_OP_JSP, 1'b0, 9'h0, 15'h005C));
		ld(15'h005C, hlt);
		run(15'h005A, 2 * CT);
		apb(1'b0, `CDCC_REG_IA, 32'h0);
		`CHK(rq, 32'h0000_005B)
		apb(1'b0, `CDCC_REG_PC, 32'h0);
		`CHK(rq, 32'h0000_005D)
		apb(1'b0, `CDCC_REG_MISC, 32'h0);
		`CHK(rq[5:0], `CDCC_OP_OPR)
		ld(15'h0203, SV);
		for (int m = 0; m < 3; m++) begin
			case (m)
				0: begin y = 15'h0005; e = SV >> 5; end
				1: begin y = 15'h0403; e = SV << 3; end
				default: begin y = 15'h0204; e = $signed(SV) >>> 4; end
			endcase
			ld(15'h0068, w(`CDCC_OP_LIO, 1'b0, 9'h0, 15'h0203));
			ld(15'h0069, w(`CDCC_OP_SFT, 1'b0, 9'h0, y));
			ld(15'h006A, hlt);
			run(15'h0068, 4 * CT + int'(y[3:0]) * ST);
			rd36(`CDCC_REG_IOL, v);
			`CHK(v, e)
		end
		ld(15'h0204, 36'h123456789);
		ld(15'h0205, 36'h000000010);
		ld(15'h0070, w(`CDCC_OP_LAC, 1'b0, 9'h0, 15'h0204));
		ld(15'h0071, w(`CDCC_OP_MUL, 1'b0, 9'h0, 15'h0205));
		ld(15'h0072, hlt);
		run(15'h0070, 0);
		p = 72'(36'h123456789) * 72'(36'h000000010);
		rd36(`CDCC_REG_ACL, v);
		`CHK(v, p[71:36])
		rd36(`CDCC_REG_IOL, v);
		`CHK(v, p[35:0])
		ld(15'h0206, 36'h5);
		ld(15'h0207, 36'h123456789);
		ld(15'h0208, 36'h007654321);
		ld(15'h0074, w(`CDCC_OP_LAC, 1'b0, 9'h0, 15'h0206));
		ld(15'h0075, w(`CDCC_OP_LIO, 1'b0, 9'h0, 15'h0207));
		ld(15'h0076, w(`CDCC_OP_DIV, 1'b0, 9'h0, 15'h0208));
		ld(15'h0077, hlt);
		run(15'h0074, 0);
		p = {36'h5, 36'h123456789};
		rd36(`CDCC_REG_IOL, v);
		`CHK(v, 36'(p / 72'(36'h007654321)))
		rd36(`CDCC_REG_ACL, v);
		`CHK(v, 36'(p % 72'(36'h007654321)))
		// Skip chain: each wrong turn except at 84 lands on the trap at 7F
		test_word <= 36'h000ABCD00;
		sense_sw <= 6'b010000;
		ld(15'h007F, hlt);
		ld(15'h0080, w(`CDCC_OP_LAC, 1'b0, 9'h0, 15'h0205));
		ld(15'h0081, w(`CDCC_OP_OPR, 1'b0, 9'h0, 15'h000B));
		ld(15'h0082, w(`CDCC_OP_SKP, 1'b0, 9'h0, 15'h0003));
		ld(15'h0083, w(`CDCC_OP_JMP, 1'b0, 9'h0, 15'h007F));
		ld(15'h0084, w(`CDCC_OP_SKP, 1'b0, 9'h0, 15'h0007));
		ld(15'h0085, w(`CDCC_OP_OPR, 1'b0, 9'h0, 15'h0010));
		ld(15'h0086, w(`CDCC_OP_OPR, 1'b0, 9'h0, 15'h0007));
		ld(15'h0087, w(`CDCC_OP_SKP, 1'b0, 9'h0, 15'h0007));
		ld(15'h0088, w(`CDCC_OP_JMP, 1'b0, 9'h0, 15'h007F));
		ld(15'h0089, w(`CDCC_OP_SKP, 1'b0, 9'h0, 15'h0028));
		ld(15'h008A, w(`CDCC_OP_JMP, 1'b0, 9'h0, 15'h007F));
		ld(15'h008B, hlt);
		run(15'h0080, 10 * CT);
		apb(1'b0, `CDCC_REG_PC, 32'h0);
		`CHK(rq, 32'h0000_008C)
		apb(1'b0, `CDCC_REG_MISC, 32'h0);
		`CHK(rq[13:8], 6'h00)
		rd36(`CDCC_REG_ACL, v);
		`CHK(v, 36'h000ABCD10)
		i_mem.io_dly = 6;
		i_mem.io_val = 36'h5A5A51234;
		ld(15'h0090, w(`CDCC_OP_IOT, 1'b1, 9'h0, 15'h0012));
		ld(15'h0091, hlt);
		start(15'h0090, 32'h1);
		for (int n = 0; n < 200 && io_done !== 1'b1; n++) @(posedge pclk);
		@(posedge pclk);
		`CHK({mem_req.rd, mem_req.addr}, {1'b1, 18'h00091})
		tail(0);
		`CHK(io_req.cmd, 18'h00012)
		`CHK(io_req.data, 36'h5A5A51234)
		rd36(`CDCC_REG_IOL, v);
		`CHK(v, 36'h5A5A51234)
		i_mem.io_dly = 3;
		i_mem.io_val = 36'h000000FFF;
		ld(15'h0092, w(`CDCC_OP_IOT, 1'b0, 9'h0, 15'h0013));
		ld(15'h0093, hlt);
		run(15'h0092, 2 * CT);
		rd36(`CDCC_REG_IOL, v);
		`CHK(v, 36'h5A5A51234)
		test_word <= 36'h800000001;
		start(15'h0300, 32'h4);
		tail(0);
		`CHK(i_mem.mem[15'h0300], 36'h800000001)
		start(15'h0201, 32'h2);
		tail(0);
		rd36(`CDCC_REG_MBL, v);
		`CHK(v, OPB)
		// Tight jump loop, then a stop request ends it before the next fetch
		ld(15'h00A0, w(`CDCC_OP_JMP, 1'b0, 9'h0, 15'h00A0));
		start(15'h00A0, 32'h1);
		apb(1'b0, `CDCC_REG_STAT, 32'h0);
		`CHK(rq[0], 1'b1)
		apb(1'b1, `CDCC_REG_CTRL, 32'h8);
		tail(0);
		apb(1'b0, `CDCC_REG_STAT, 32'h0);
		`CHK(rq, 32'h0)
		apb(1'b0, `CDCC_REG_MA, 32'h0);
		`CHK(rq, 32'h0000_00A0)
		apb(1'b0, `CDCC_REG_PC, 32'h0);
		`CHK(rq, 32'h0000_00A0)
		test_done();
	end
endmodule : cdcc_core_bench
